//--- verilog/fscr_regs.sv
`timescale 1ns/1ps
module fscr_regs #(
    parameter int NUM_DIE = fscr_pkg::NUM_DIE_DEF,
    parameter int DIE_W   = 2
) (
    // clocks and reset
    input  wire logic                       clk_sys,
    input  wire logic                       clk_link,
    input  wire logic                       rst,
    // link command port (clk_link)
    input  wire logic                       lnk_req,
    input  wire logic [3:0]                 lnk_op,
    input  wire logic [DIE_W-1:0]           lnk_die,
    input  wire logic [15:0]                lnk_wdata,
    output logic                            lnk_ready,
    output logic                            lnk_rvalid,
    output logic [15:0]                     lnk_rdata,
    // write-protect pin
    input  wire logic                       wp_n,
    // array engine (clk_sys)
    input  wire logic                       pe_req,
    input  wire logic [DIE_W-1:0]           pe_die,
    input  wire logic [fscr_pkg::SECT_W-1:0] pe_sector,
    input  wire logic                       pe_die_erase,
    input  wire logic                       pe_done,
    output logic                            pe_grant,
    output logic                            pe_refuse,
    // per-die status
    output logic [NUM_DIE-1:0]              sts_busy,
    output logic [NUM_DIE-1:0]              pe_ctrl_ready,
    // per-die working configuration
    output logic [NUM_DIE*4-1:0]            cfg_dummy,
    output logic [NUM_DIE*3-1:0]            cfg_xip_mode,
    output logic [NUM_DIE-1:0]              cfg_xip_en,
    output logic [NUM_DIE*2-1:0]            cfg_protocol,
    output logic [NUM_DIE-1:0]              cfg_hold_en,
    output logic [NUM_DIE-1:0]              cfg_seg_lower,
    output logic [NUM_DIE-1:0]              cfg_addr4
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [3:0] dummy_resolve(input logic [3:0] code);
        dummy_resolve = (code == 4'h0 || code == 4'hF) ? fscr_pkg::DUMMY_DEF : code;
    endfunction

    function automatic logic prot_hit(input logic [5:0] srn,
                                      input logic [fscr_pkg::SECT_W-1:0] sect,
                                      input logic whole);
        logic [3:0]  bp;
        logic [11:0] n;
        logic [11:0] s;
        bp = {srn[fscr_pkg::SRN_BP3], srn[2:0]};
        s  = {1'b0, sect};
        n  = (bp >= 4'hC) ? fscr_pkg::SECTORS : (12'h001 << (bp - 4'h1));
        if (bp == 4'h0)
            prot_hit = 1'b0;
        else if (whole)
            prot_hit = 1'b1;
        else if (srn[fscr_pkg::SRN_TB])
            prot_hit = (s < n);                                   // [R5] [R6]
        else
            prot_hit = (s >= fscr_pkg::SECTORS - n);              // [R5] [R6]
    endfunction

    // ------------------------------------------------------------------
    // link domain: request hold and toggle
    // ------------------------------------------------------------------
    logic             l_pend_r;
    logic             l_req_tgl_r;
    logic [3:0]       l_op_r;
    logic [DIE_W-1:0] l_die_r;
    logic [15:0]      l_wdata_r;
    logic             l_ack_s1_r;
    logic             l_ack_s2_r;
    logic             l_ack_seen_r;
    logic             l_rvalid_r;
    logic [15:0]      l_rdata_r;
    logic             s_ack_tgl_r;
    logic [15:0]      s_rdata_r;
    logic             l_take;
    logic             l_ack_new;

    assign l_take     = lnk_req & ~l_pend_r;
    assign l_ack_new  = l_ack_s2_r ^ l_ack_seen_r;
    assign lnk_ready  = ~l_pend_r;
    assign lnk_rvalid = l_rvalid_r;
    assign lnk_rdata  = l_rdata_r;

    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            l_pend_r    <= 1'b0;
            l_req_tgl_r <= 1'b0;
            l_op_r      <= 4'h0;
            l_die_r     <= '0;
            l_wdata_r   <= 16'h0000;
        end else if (l_take) begin
            l_pend_r    <= 1'b1;
            l_req_tgl_r <= ~l_req_tgl_r;
            l_op_r      <= lnk_op;
            l_die_r     <= lnk_die;
            l_wdata_r   <= lnk_wdata;
        end else if (l_ack_new) begin
            l_pend_r    <= 1'b0;
        end
    end

    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            l_ack_s1_r   <= 1'b0;
            l_ack_s2_r   <= 1'b0;
            l_ack_seen_r <= 1'b0;
            l_rvalid_r   <= 1'b0;
            l_rdata_r    <= 16'h0000;
        end else begin
            l_ack_s1_r   <= s_ack_tgl_r;
            l_ack_s2_r   <= l_ack_s1_r;
            l_ack_seen_r <= l_ack_s2_r;
            l_rvalid_r   <= l_ack_new;
            if (l_ack_new)
                l_rdata_r <= s_rdata_r;
        end
    end

    // ------------------------------------------------------------------
    // system domain: synchronisers
    // ------------------------------------------------------------------
    logic s_req_s1_r;
    logic s_req_s2_r;
    logic s_req_seen_r;
    logic wp_s1_r;
    logic wp_s2_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_req_s1_r   <= 1'b0;
            s_req_s2_r   <= 1'b0;
            s_req_seen_r <= 1'b0;
            wp_s1_r      <= 1'b0;
            wp_s2_r      <= 1'b0;
        end else begin
            s_req_s1_r   <= l_req_tgl_r;
            s_req_s2_r   <= s_req_s1_r;
            s_req_seen_r <= s_req_s2_r;
            wp_s1_r      <= wp_n;
            wp_s2_r      <= wp_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // per-die state and the shared boot flag
    // ------------------------------------------------------------------
    logic [5:0]                 sr_nv_r   [NUM_DIE];
    logic [5:0]                 sr_pend_r [NUM_DIE];
    logic [15:0]                nv_r      [NUM_DIE];
    logic [15:0]                nv_pend_r [NUM_DIE];
    logic                       wel_r     [NUM_DIE];
    logic                       perr_r    [NUM_DIE];
    fscr_pkg::fscr_busy_e       bk_r      [NUM_DIE];
    logic [7:0]                 bcnt_r    [NUM_DIE];
    logic [3:0]                 wk_dummy_r [NUM_DIE];
    logic [2:0]                 wk_xip_r   [NUM_DIE];
    logic                       wk_xen_r   [NUM_DIE];
    fscr_pkg::fscr_proto_e      wk_proto_r [NUM_DIE];
    logic                       wk_hold_r  [NUM_DIE];
    logic                       wk_seg_r   [NUM_DIE];
    logic                       wk_addr4_r [NUM_DIE];
    logic                       boot_r;

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    fscr_pkg::fscr_op_e op;
    logic               fire;
    logic [NUM_DIE-1:0] sel;
    logic [NUM_DIE-1:0] busy;
    logic [NUM_DIE-1:0] sr_go;
    logic [NUM_DIE-1:0] nv_go;
    logic [NUM_DIE-1:0] pe_ok;
    logic [NUM_DIE-1:0] pe_err;
    logic [NUM_DIE-1:0] done;

    assign op   = fscr_pkg::fscr_op_e'(l_op_r);
    assign fire = s_req_s2_r ^ s_req_seen_r;

    always_comb begin
        for (int i = 0; i < NUM_DIE; i++) begin
            sel[i]    = fire && (l_die_r == DIE_W'(i));              // [R22]
            busy[i]   = (bk_r[i] != fscr_pkg::BK_IDLE);
            sr_go[i]  = sel[i] && op == fscr_pkg::OP_WR_STATUS && wel_r[i] && !busy[i]
                        && !(sr_nv_r[i][fscr_pkg::SRN_LOCK] && !wp_s2_r); // [R4] [R7] [R20]
            nv_go[i]  = sel[i] && op == fscr_pkg::OP_WR_NVCFG && wel_r[i]
                        && !busy[i];                                // [R7] [R21]
            pe_ok[i]  = pe_req && pe_die == DIE_W'(i) && wel_r[i] && !busy[i]
                        && !prot_hit(sr_nv_r[i], pe_sector, pe_die_erase); // [R6] [R7]
            pe_err[i] = pe_req && pe_die == DIE_W'(i) && wel_r[i] && !busy[i]
                        && prot_hit(sr_nv_r[i], pe_sector, pe_die_erase);
            done[i]   = (bk_r[i] == fscr_pkg::BK_PE) ? (pe_done && pe_die == DIE_W'(i))
                        : (busy[i] && bcnt_r[i] == 8'h00);
        end
    end

    // ------------------------------------------------------------------
    // read answer and acknowledge
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_ack_tgl_r <= 1'b0;
            s_rdata_r   <= 16'h0000;
        end else if (fire) begin
            s_ack_tgl_r <= ~s_ack_tgl_r;
            s_rdata_r   <= 16'h0000;
            for (int i = 0; i < NUM_DIE; i++) begin
                if (sel[i] && op == fscr_pkg::OP_RD_STATUS)
                    s_rdata_r <= {8'h00, sr_nv_r[i], wel_r[i], busy[i]}; // [R20]
                if (sel[i] && op == fscr_pkg::OP_RD_NVCFG)
                    s_rdata_r <= nv_r[i];                            // [R21]
            end
        end
    end

    // ------------------------------------------------------------------
    // busy tracking
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_DIE; i++) begin
                bk_r[i]   <= fscr_pkg::BK_IDLE;                      // [R9]
                bcnt_r[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < NUM_DIE; i++) begin
                if (sr_go[i]) begin
                    bk_r[i]   <= fscr_pkg::BK_SR;                    // [R8]
                    bcnt_r[i] <= 8'(fscr_pkg::WR_BUSY_CYC - 1);
                end else if (nv_go[i]) begin
                    bk_r[i]   <= fscr_pkg::BK_NV;                    // [R8]
                    bcnt_r[i] <= 8'(fscr_pkg::WR_BUSY_CYC - 1);
                end else if (pe_ok[i]) begin
                    bk_r[i]   <= fscr_pkg::BK_PE;                    // [R8]
                end else if (done[i]) begin
                    bk_r[i]   <= fscr_pkg::BK_IDLE;
                end else if (bcnt_r[i] != 8'h00) begin
                    bcnt_r[i] <= bcnt_r[i] - 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // nonvolatile status and boot configuration
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_DIE; i++) begin
                sr_nv_r[i]   <= fscr_pkg::SR_NV_RST;
                sr_pend_r[i] <= fscr_pkg::SR_NV_RST;
                nv_r[i]      <= fscr_pkg::NVCFG_RST;                 // [R19]
                nv_pend_r[i] <= fscr_pkg::NVCFG_RST;
            end
        end else begin
            for (int i = 0; i < NUM_DIE; i++) begin
                if (sr_go[i])
                    sr_pend_r[i] <= l_wdata_r[7:fscr_pkg::SR_NV_LO];
                if (nv_go[i])
                    nv_pend_r[i] <= l_wdata_r;
                if (done[i] && bk_r[i] == fscr_pkg::BK_SR)
                    sr_nv_r[i] <= sr_pend_r[i];                      // [R20]
                if (done[i] && bk_r[i] == fscr_pkg::BK_NV)
                    nv_r[i] <= nv_pend_r[i];                         // [R21]
            end
        end
    end

    // ------------------------------------------------------------------
    // write-enable latch and protection error
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_DIE; i++) begin
                wel_r[i]  <= 1'b0;                                   // [R7] [R9]
                perr_r[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < NUM_DIE; i++) begin
                if (pe_err[i]) begin
                    wel_r[i]  <= 1'b1;                               // [R10]
                    perr_r[i] <= 1'b1;
                end else if (sel[i] && op == fscr_pkg::OP_CLR_FLAG) begin
                    wel_r[i]  <= 1'b0;                               // [R10]
                    perr_r[i] <= 1'b0;
                end else if (sel[i] && op == fscr_pkg::OP_WR_EN) begin
                    wel_r[i]  <= 1'b1;                               // [R7]
                end else if (!perr_r[i] && (done[i]
                             || (sel[i] && op == fscr_pkg::OP_WR_DIS))) begin
                    wel_r[i]  <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // working configuration: boot load and volatile updates
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            boot_r <= 1'b1;                                          // [R3]
            for (int i = 0; i < NUM_DIE; i++) begin
                wk_dummy_r[i] <= fscr_pkg::DUMMY_DEF;
                wk_xip_r[i]   <= 3'h7;
                wk_xen_r[i]   <= 1'b0;
                wk_proto_r[i] <= fscr_pkg::PROTO_EXT;
                wk_hold_r[i]  <= 1'b1;
                wk_seg_r[i]   <= 1'b1;
                wk_addr4_r[i] <= 1'b0;
            end
        end else begin
            boot_r <= 1'b0;
            for (int i = 0; i < NUM_DIE; i++) begin
                if (boot_r) begin                                    // [R1] [R3]
                    wk_dummy_r[i] <= dummy_resolve(nv_r[i][15:12]);  // [R12]
                    wk_xip_r[i]   <= nv_r[i][11:9];
                    wk_xen_r[i]   <= (nv_r[i][11:9] <= fscr_pkg::XIP_LAST); // [R14]
                    if (!nv_r[i][fscr_pkg::NV_QUAD])                 // [R16]
                        wk_proto_r[i] <= fscr_pkg::PROTO_QUAD;
                    else if (!nv_r[i][fscr_pkg::NV_DUAL])
                        wk_proto_r[i] <= fscr_pkg::PROTO_DUAL;
                    else
                        wk_proto_r[i] <= fscr_pkg::PROTO_EXT;
                    wk_hold_r[i]  <= nv_r[i][fscr_pkg::NV_HOLD];     // [R15]
                    wk_seg_r[i]   <= nv_r[i][fscr_pkg::NV_SEG];      // [R17]
                    wk_addr4_r[i] <= ~nv_r[i][fscr_pkg::NV_ADDR];    // [R18]
                end else if (sel[i] && op == fscr_pkg::OP_WR_VCFG) begin // [R2]
                    wk_dummy_r[i] <= dummy_resolve(l_wdata_r[7:4]);  // [R12]
                    wk_xen_r[i]   <= ~l_wdata_r[fscr_pkg::VC_XIP]
                                     && (wk_xip_r[i] <= fscr_pkg::XIP_LAST);
                end else if (sel[i] && op == fscr_pkg::OP_WR_EVCFG) begin // [R2]
                    if (!l_wdata_r[fscr_pkg::EV_QUAD])
                        wk_proto_r[i] <= fscr_pkg::PROTO_QUAD;
                    else if (!l_wdata_r[fscr_pkg::EV_DUAL])
                        wk_proto_r[i] <= fscr_pkg::PROTO_DUAL;
                    else
                        wk_proto_r[i] <= fscr_pkg::PROTO_EXT;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // array engine answers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pe_grant  <= 1'b0;
            pe_refuse <= 1'b0;
        end else begin
            pe_grant  <= |pe_ok;                                     // [R6]
            pe_refuse <= pe_req && ~|pe_ok;                          // [R6] [R7]
        end
    end

    // ------------------------------------------------------------------
    // flattened outputs
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_DIE; i++) begin
            sts_busy[i]           = busy[i];                         // [R8]
            pe_ctrl_ready[i]      = ~busy[i];                        // [R11]
            cfg_dummy[i*4 +: 4]   = wk_dummy_r[i];
            cfg_xip_mode[i*3 +: 3] = wk_xip_r[i];
            cfg_xip_en[i]         = wk_xen_r[i];
            cfg_protocol[i*2 +: 2] = wk_proto_r[i];
            cfg_hold_en[i]        = wk_hold_r[i];
            cfg_seg_lower[i]      = wk_seg_r[i];
            cfg_addr4[i]          = wk_addr4_r[i];
        end
    end

endmodule // fscr_regs

//--- verilog/fscr_pkg.sv
// Functional notes
// R1: reset release loads working config from boot config.
// R2: volatile writes update working config at once.
// R3: later reset drops volatile changes.
// R4: lock bit with write-protect low blocks status writes.
// R5: top/bottom bit: 0 top, 1 bottom.
// R6: program/erase into protected region refused.
// R7: write-enable latch clear at power-up; writes need it set. Volatile and enhanced volatile config writes go ahead without it.
// R8: busy set during status/config write, program, erase.
// R9: volatile status bits clear on reset.
// R10: protection error sets write-enable; only clear-flag clears.
// R11: controller ready is inverse of busy.
// R12: dummy count from 15:12; 0000, 1111 give default.
// R13: host picks dummy count fit for clock and read type.
// R14: 11:9 picks execute-in-place read; 101, 110 reserved; 111 off.
// R15: bit 4 enables hold/reset pin function.
// R16: bit 2 low dual, bit 3 low quad, both low quad.
// R17: bit 1 picks 3-byte segment: 0 upper, 1 lower.
// R18: bit 0 picks address width: 0 four, 1 three bytes.
// R19: boot configuration resets to all ones.
// R20: status reached only by its read and write commands.
// R21: boot config reached only by its own commands.
// R22: each stacked die keeps its own copy.
package fscr_pkg;

    // ------------------------------------------------------------------
    // sizes and reset values
    // ------------------------------------------------------------------
    localparam int          NUM_DIE_DEF  = 4;
    localparam int          SECT_W       = 11;
    localparam logic [11:0] SECTORS      = 12'h800;
    localparam logic [15:0] NVCFG_RST    = 16'hFFFF;
    localparam logic [5:0]  SR_NV_RST    = 6'h00;
    localparam logic [3:0]  DUMMY_DEF    = 4'hA;

    // ------------------------------------------------------------------
    // status fields (nonvolatile part indexed from bit 2)
    // ------------------------------------------------------------------
    localparam int SR_NV_LO  = 2;
    localparam int SRN_LOCK  = 5;
    localparam int SRN_BP3   = 4;
    localparam int SRN_TB    = 3;

    // ------------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------------
    localparam int NV_DUMMY_LO = 12;
    localparam int NV_XIP_LO   = 9;
    localparam int NV_HOLD     = 4;
    localparam int NV_QUAD     = 3;
    localparam int NV_DUAL     = 2;
    localparam int NV_SEG      = 1;
    localparam int NV_ADDR     = 0;
    localparam int VC_DUMMY_LO = 4;
    localparam int VC_XIP      = 3;
    localparam int EV_QUAD     = 7;
    localparam int EV_DUAL     = 6;
    localparam logic [2:0] XIP_LAST = 3'h4;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_SYS_MHZ = 200;
    localparam int WR_BUSY_NS  = 1000;
    localparam int WR_BUSY_CYC = (WR_BUSY_NS * CLK_SYS_MHZ + 999) / 1000;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE, OP_RD_STATUS, OP_WR_STATUS, OP_WR_EN, OP_WR_DIS,
        OP_RD_NVCFG, OP_WR_NVCFG, OP_WR_VCFG, OP_WR_EVCFG, OP_CLR_FLAG
    } fscr_op_e;

    typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} fscr_proto_e;

    typedef enum logic [1:0] {BK_IDLE, BK_SR, BK_NV, BK_PE} fscr_busy_e;

endpackage

//--- bench/fscr_checker.sv
`timescale 1ns/1ps
module fscr_checker #(parameter int NUM_DIE = 4, parameter int DIE_W = 2) (
    // watched ports
    input wire logic                 clk_sys, clk_link, rst, lnk_req, lnk_ready, lnk_rvalid,
    input wire logic                 pe_req, pe_done, pe_grant, pe_refuse,
    input wire logic [DIE_W-1:0]     pe_die,
    input wire logic [NUM_DIE-1:0]   sts_busy, pe_ctrl_ready, cfg_xip_en,
    input wire logic [NUM_DIE*4-1:0] cfg_dummy,
    input wire logic [NUM_DIE*2-1:0] cfg_protocol
);
    // ----------------
    // assertions
    // ----------------
    ready_inv_a: assert property (@(posedge clk_sys) disable iff (rst)
        pe_ctrl_ready == ~sts_busy) else $error("ready not ~busy");
    pe_answer_a: assert property (@(posedge clk_sys) disable iff (rst)
        pe_req |=> pe_grant != pe_refuse) else $error("no single answer");
    no_answer_a: assert property (@(posedge clk_sys) disable iff (rst)
        !pe_req |=> !(pe_grant || pe_refuse)) else $error("stray answer");
    grant_busy_a: assert property (@(posedge clk_sys) disable iff (rst)
        pe_grant |-> sts_busy != '0) else $error("grant without busy");
    done_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
        pe_done && pe_die == '0 && sts_busy[0] |=> !sts_busy[0]) else $error("busy after done");
    dummy_ok_a: assert property (@(posedge clk_sys) disable iff (rst)
        cfg_dummy[3:0] != 4'h0 && cfg_dummy[3:0] != 4'hF) else $error("dummy unresolved");
    proto_ok_a: assert property (@(posedge clk_sys) disable iff (rst)
        cfg_protocol[1:0] != 2'h3) else $error("bad protocol");
    boot_cfg_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(rst) |-> cfg_protocol == '0 && cfg_xip_en == '0) else $error("boot cfg wrong");
    rv_pulse_a: assert property (@(posedge clk_link) disable iff (rst)
        lnk_rvalid |=> !lnk_rvalid) else $error("rvalid too long");
    take_hold_a: assert property (@(posedge clk_link) disable iff (rst)
        lnk_req && lnk_ready |=> !lnk_ready [*3]) else $error("ready too soon");
    take_ans_a: assert property (@(posedge clk_link) disable iff (rst)
        lnk_req && lnk_ready |-> ##[1:100] lnk_rvalid) else $error("no link answer");
    cover property (@(posedge clk_sys) pe_grant);
    cover property (@(posedge clk_sys) pe_refuse);
    cover property (@(posedge clk_link) lnk_rvalid);
endmodule // fscr_checker
bind fscr_regs fscr_checker #(.NUM_DIE(NUM_DIE), .DIE_W(DIE_W)) fscr_checker_inst (.*);

//--- bench/fscr_host.sv
`timescale 1ns/1ps
module fscr_host (
    // link side
    input  wire logic        clk_link,
    input  wire logic        lnk_ready,
    input  wire logic        lnk_rvalid,
    input  wire logic [15:0] lnk_rdata,
    output logic             lnk_req,
    output logic [3:0]       lnk_op,
    output logic [1:0]       lnk_die,
    output logic [15:0]      lnk_wdata
);
    initial {lnk_req, lnk_op, lnk_die, lnk_wdata} = '0;
    // one held command
    task automatic cmd(input logic [3:0] op, input logic [1:0] die,
                       input logic [15:0] wd, output logic [15:0] rd);
        int n;
        n = 0;
        lnk_req   <= 1'b1;
        lnk_op    <= op;
        lnk_die   <= die;
        lnk_wdata <= wd;
        do @(posedge clk_link); while (!lnk_ready);
        lnk_req   <= 1'b0;
        do begin
            @(posedge clk_link);
            n++;
        end while (!lnk_rvalid && n < 200);
        rd = lnk_rdata;
    endtask
endmodule // fscr_host

//--- bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, e, a); end end
module tb_top;
    logic        clk_sys = 1'b0, clk_link = 1'b0, rst = 1'b1, wp_n = 1'b1;
    logic        pe_req = 1'b0, pe_done = 1'b0, lnk_req, lnk_ready, lnk_rvalid;
    logic        pe_grant, pe_refuse;
    logic [1:0]  lnk_die;
    logic [3:0]  lnk_op, sts_busy, pe_ctrl_ready, cfg_xip_en, cfg_hold_en, cfg_seg_lower, cfg_addr4;
    logic [10:0] pe_sector = 11'h000;
    logic [15:0] lnk_wdata, lnk_rdata, rd, cfg_dummy;
    logic [11:0] cfg_xip_mode;
    logic [7:0]  cfg_protocol;
    int          n_mismatch = 0, n_checks = 0;
    always #2.5 clk_sys = ~clk_sys;
    initial begin #1.1; forever #7.5 clk_link = ~clk_link; end
    fscr_regs fscr_regs_inst (.clk_sys, .clk_link, .rst, .lnk_req, .lnk_op, .lnk_die, .lnk_wdata,
        .lnk_ready, .lnk_rvalid, .lnk_rdata, .wp_n, .pe_req, .pe_die(2'h0), .pe_sector,
        .pe_die_erase(1'b0), .pe_done, .pe_grant, .pe_refuse, .sts_busy, .pe_ctrl_ready,
        .cfg_dummy, .cfg_xip_mode, .cfg_xip_en, .cfg_protocol, .cfg_hold_en, .cfg_seg_lower,
        .cfg_addr4);
    fscr_host fscr_host_inst (.clk_link, .lnk_ready, .lnk_rvalid, .lnk_rdata, .lnk_req, .lnk_op,
        .lnk_die, .lnk_wdata);
    task automatic cmd(input logic [3:0] op, input logic [15:0] wd = 16'h0000);
        @(posedge clk_link);
        fscr_host_inst.cmd(op, 2'h0, wd, rd);
    endtask
    task automatic chk_sr(input logic [7:0] e);
        cmd(fscr_pkg::OP_RD_STATUS);
        `CHK("status", {8'h00, e}, rd)
    endtask
    task automatic wait_idle;
        `CHK("busy set", 1'b1, sts_busy[0])
        for (int i = 0; i < 400 && sts_busy[0]; i++) @(posedge clk_sys);
        #1;
        `CHK("busy clear", 1'b0, sts_busy[0])
    endtask
    task automatic pe(input logic [10:0] s, input logic g);
        @(posedge clk_sys);
        pe_req    <= 1'b1;
        pe_sector <= s;
        @(posedge clk_sys);
        pe_req <= 1'b0;
        #1;
        `CHK("grant", g, pe_grant)
        `CHK("refuse", !g, pe_refuse)
        if (g) begin
            `CHK("pe ready", 1'b0, pe_ctrl_ready[0])
            @(posedge clk_sys) pe_done <= 1'b1;
            @(posedge clk_sys) pe_done <= 1'b0;
            #1;
            `CHK("pe busy", 1'b0, sts_busy[0])
        end
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic t_boot;
        `CHK("dummy", 16'hAAAA, cfg_dummy)
        `CHK("proto", 8'h00, cfg_protocol)
        `CHK("xip", 4'h0, cfg_xip_en)
        `CHK("hold", 4'hF, cfg_hold_en)
        `CHK("seg", 4'hF, cfg_seg_lower)
        `CHK("addr4", 4'h0, cfg_addr4)
        chk_sr(8'h00);
        cmd(fscr_pkg::OP_RD_NVCFG);
        `CHK("boot cfg", 16'hFFFF, rd)
        $display("test boot done");
    endtask
    task automatic t_vol;
        cmd(fscr_pkg::OP_WR_VCFG, 16'h0038);
        `CHK("dummy v", 4'h3, cfg_dummy[3:0])
        `CHK("die1 dummy", 4'hA, cfg_dummy[7:4])
        cmd(fscr_pkg::OP_WR_EVCFG, 16'h007F);
        `CHK("quad", 2'h2, cfg_protocol[1:0])
        cmd(fscr_pkg::OP_WR_EVCFG, 16'h00BF);
        `CHK("dual", 2'h1, cfg_protocol[1:0])
        do_reset;
        `CHK("dummy rst", 4'hA, cfg_dummy[3:0])
        `CHK("proto rst", 2'h0, cfg_protocol[1:0])
        $display("test vol done");
    endtask
    task automatic t_nv;
        cmd(fscr_pkg::OP_WR_NVCFG, 16'h57E4);
        cmd(fscr_pkg::OP_RD_NVCFG);
        `CHK("nv no wel", 16'hFFFF, rd)
        cmd(fscr_pkg::OP_WR_EN);
        chk_sr(8'h02);
        cmd(fscr_pkg::OP_WR_NVCFG, 16'h57E4);
        wait_idle;
        cmd(fscr_pkg::OP_RD_NVCFG);
        `CHK("nv data", 16'h57E4, rd)
        `CHK("addr4 kept", 4'h0, cfg_addr4)
        chk_sr(8'h00);
        $display("test nv done");
    endtask
    task automatic t_prot;
        pe(11'h7FF, 1'b0);
        cmd(fscr_pkg::OP_WR_EN);
        cmd(fscr_pkg::OP_WR_STATUS, 16'h00AC);
        wait_idle;
        chk_sr(8'hAC);
        cmd(fscr_pkg::OP_WR_EN);
        pe(11'h003, 1'b0);
        cmd(fscr_pkg::OP_WR_DIS);
        chk_sr(8'hAE);
        cmd(fscr_pkg::OP_CLR_FLAG);
        chk_sr(8'hAC);
        cmd(fscr_pkg::OP_WR_EN);
        pe(11'h004, 1'b1);
        @(posedge clk_sys) wp_n <= 1'b0;
        cmd(fscr_pkg::OP_WR_EN);
        cmd(fscr_pkg::OP_WR_STATUS, 16'h0000);
        `CHK("locked busy", 1'b0, sts_busy[0])
        chk_sr(8'hAE);
        @(posedge clk_sys) wp_n <= 1'b1;
        cmd(fscr_pkg::OP_WR_STATUS, 16'h0000);
        wait_idle;
        chk_sr(8'h00);
        $display("test prot done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        do_reset;
        t_boot;
        t_vol;
        t_nv;
        t_prot;
        print_verdict;
    end
    // about twenty-five times the expected run
    initial begin
        #150000;
        n_mismatch++;
        print_verdict;
    end
endmodule // tb_top
